//--- hw/els_pkg.sv
// Purpose: Shared constants for the link statistics counter block
// Assumes: One 40 MHz clock, byte-addressed 32-bit register port
// Notes: Counters are 64-bit wide; the older format clamps them narrower
package els_pkg;
    localparam int CW = 64;
    localparam int AW = 8;
    localparam int CNT_N = 17;
    localparam int IDX_W = 5;
    // Counter indices
    localparam int RX_OCT = 0;
    localparam int TX_OCT = 1;
    localparam int RX_FRM = 2;
    localparam int TX_FRM = 3;
    localparam int GRP_OCT = 4;
    localparam int GRP_FRM = 5;
    localparam int DEFER1 = 6;
    localparam int COLL1 = 7;
    localparam int COLLN = 8;
    localparam int XF_RETRY = 9;
    localparam int XF_NOCAR = 10;
    localparam int RF_CRC = 11;
    localparam int RF_ALIGN = 12;
    localparam int RF_OVER = 13;
    localparam int UNMATCHED = 14;
    localparam int OVERRUN = 15;
    localparam int CD_MISS = 16;
    // Older format widths
    localparam logic [6:0] OLD_W_WIDE = 7'h20;
    localparam logic [6:0] OLD_W_NARROW = 7'h10;
    localparam logic [15:0] OLD_MAX16 = 16'hffff;
    // Register byte addresses
    localparam logic [AW-1:0] A_CTRL = 8'h00;
    localparam logic [AW-1:0] A_STATUS = 8'h04;
    localparam logic [AW-1:0] A_ELAPSED_LO = 8'h08;
    localparam logic [AW-1:0] A_ELAPSED_HI = 8'h0c;
    localparam logic [AW-1:0] A_CNT_BASE = 8'h10;
    localparam logic [AW-1:0] A_XMIT_FAIL_OLD = 8'h98;
    localparam logic [AW-1:0] A_RECV_FAIL_OLD = 8'h9c;
    localparam logic [AW-1:0] A_ZERO_FIRST = 8'ha0;
    localparam logic [AW-1:0] A_ZERO_LAST = 8'hfc;
    // Control bits
    localparam int CTRL_FMT_BIT = 0;
    localparam int CTRL_ZERO_BIT = 1;
    localparam int CTRL_SNAP_BIT = 2;
    localparam logic CTRL_FMT_RST = 1'b1;
    // Failure kinds
    localparam logic [2:0] TXK_RETRY = 3'h0;
    localparam logic [2:0] TXK_NOCAR = 3'h1;
    localparam logic [2:0] TXK_NONE = 3'h7;
    localparam logic [1:0] RXK_NONE = 2'h0;
    localparam logic [1:0] RXK_CRC = 2'h1;
    localparam logic [1:0] RXK_ALIGN = 2'h2;
    localparam logic [1:0] RXK_OVER = 2'h3;
    // Timing
    localparam int CLK_NS = 25;
    localparam int TICK_NS = 100;
    localparam int TICK_CYC = TICK_NS / CLK_NS;
    localparam longint SEC_NS = 1000000000;
    localparam int SEC_CYC_DEF = int'(SEC_NS / CLK_NS);
endpackage : els_pkg

//--- hw/els_counters.sv
// Purpose: Ethernet link statistics counters with read-and-zero port
// Assumes: Controller events are on SYS_CLK, one strobe per frame outcome
// Notes: Counter, elapsed and failure reads come from a snapshot taken by the control register; control and status read live
//
// How it works
// - Newer format counters are unsigned and wrap to zero on overflow.
// - Older format counters saturate at all ones and stay there.
// - Counters take unicast and multicast, every protocol type.
// - Errored frames never add to received frames or received bytes.
// - Elapsed time: seconds in older format, 100 ns ticks in newer.
// - Fixed field order; 32-bit older (16-bit for unmatched and overrun) and 64-bit newer counters.
// - Received bytes add data length of good, address-matched frames.
// - Sent bytes add data length of good frames, never retries.
// - Received frames count each good address-matched frame once.
// - Sent frames count each good frame once, not its retries.
// - Multicast received bytes add length of good multicast frames.
// - Multicast received frames count good multicast frames.
// - Initial deferral counts frames sent first try after deferring.
// - Single collision counts frames sent on the second attempt.
// - Multiple collision counts frames sent on third or later attempt.
// - At most one deferral or collision counter moves per frame.
// - Older format keeps one 16-bit failure count and bitmap per direction.
// - Newer format keeps separate transmit failure counters, kinds 0 and 1.
// - Cable short/open, oversize, late remote and buffer counters read zero.
// - Newer format keeps receive CRC, alignment and oversize counters.
// - Missed collision test counter exists only in newer format.
// - Zeroing a failure count clears its bitmap; reads return the bitmap.
// - Receive failures count only address-matched frames.
// - Unmatched destination counter counts frames with no consumer.
// - Overrun counter counts frames lost to the data rate.
`timescale 1ns/100ps
module els_counters #(
    parameter int SEC_CYC = els_pkg::SEC_CYC_DEF
) (
    input wire logic SYS_CLK,
    input wire logic RST_B,
    input wire logic [els_pkg::AW-1:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    input wire logic RX_EVT,
    input wire logic [15:0] RX_LEN,
    input wire logic RX_GROUP,
    input wire logic RX_ADDR_MATCH,
    input wire logic [1:0] RX_ERR_KIND,
    input wire logic RX_UNMATCHED,
    input wire logic RX_OVERRUN,
    input wire logic TX_EVT,
    input wire logic [15:0] TX_LEN,
    input wire logic [3:0] TX_ATTEMPTS,
    input wire logic TX_DEFERRED,
    input wire logic [2:0] TX_FAIL_KIND,
    input wire logic TX_CD_MISS
);
    import els_pkg::*;

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [CNT_N-1:0][CW-1:0] cnt;
        logic [CNT_N-1:0][CW-1:0] snap;
        logic [CW-1:0] elapsed;
        logic [CW-1:0] snap_elapsed;
        logic [15:0] xf_cnt;
        logic [15:0] xf_map;
        logic [15:0] rf_cnt;
        logic [15:0] rf_map;
        logic [31:0] snap_xf;
        logic [31:0] snap_rf;
        logic fmt_new;
        logic [31:0] sec_div;
        logic [7:0] tick_div;
        logic [31:0] rdata;
    } els_state_t;

    localparam logic [31:0] SEC_LAST = 32'(SEC_CYC - 1);
    localparam logic [7:0] TICK_LAST = 8'(TICK_CYC - 1);

    els_state_t st_reg;
    els_state_t st_next;
    logic [CNT_N-1:0][CW-1:0] add;
    logic zero_req;
    logic snap_req;
    logic ctrl_wr;
    logic rx_good;
    logic rx_fail;
    logic tx_good;
    logic tx_fail;
    logic sec_pulse;
    logic tick_pulse;
    logic [AW-1:0] cnt_off;
    logic [IDX_W-1:0] cnt_idx;

    // ************************************************************
    // Helpers
    // ************************************************************
    // Older format clamps at the field width instead of wrapping
    function automatic logic [CW-1:0] bump(input logic [CW-1:0] v, input logic [CW-1:0] a,
                                           input logic sat, input logic [6:0] w);
        logic [CW:0] s;
        logic [CW-1:0] lim;
        s = {1'b0, v} + {1'b0, a};
        lim = (CW'(1) << w) - CW'(1);
        if (sat && (s > {1'b0, lim})) begin
            bump = lim;
        end else begin
            bump = s[CW-1:0];
        end
    endfunction : bump

    function automatic logic [6:0] old_width(input int idx);
        if (idx == UNMATCHED || idx == OVERRUN) begin
            old_width = OLD_W_NARROW;
        end else begin
            old_width = OLD_W_WIDE;
        end
    endfunction : old_width

    function automatic logic [15:0] sat16(input logic [15:0] v);
        sat16 = (v == OLD_MAX16) ? v : v + 16'h1;
    endfunction : sat16

    // ************************************************************
    // Event qualification
    // ************************************************************
    always_comb begin
        ctrl_wr = WR && (ADDR == A_CTRL);
        zero_req = ctrl_wr && WDATA[CTRL_ZERO_BIT];
        snap_req = ctrl_wr && WDATA[CTRL_SNAP_BIT];
        rx_good = RX_EVT && RX_ADDR_MATCH && (RX_ERR_KIND == RXK_NONE);
        rx_fail = RX_EVT && RX_ADDR_MATCH && (RX_ERR_KIND != RXK_NONE);
        tx_good = TX_EVT && (TX_FAIL_KIND == TXK_NONE);
        tx_fail = TX_EVT && (TX_FAIL_KIND != TXK_NONE);
        tick_pulse = (st_reg.tick_div == TICK_LAST);
        sec_pulse = (st_reg.sec_div == SEC_LAST);
    end

    // ************************************************************
    // Per-counter increments
    // ************************************************************
    always_comb begin
        add = '0;
        if (rx_good) begin
            add[RX_OCT] = CW'(RX_LEN);
            add[RX_FRM] = CW'(1);
        end
        if (rx_good && RX_GROUP) begin
            add[GRP_OCT] = CW'(RX_LEN);
            add[GRP_FRM] = CW'(1);
        end
        // one count per frame, retries ignored
        if (tx_good) begin
            add[TX_OCT] = CW'(TX_LEN);
            add[TX_FRM] = CW'(1);
            if (TX_ATTEMPTS >= 4'h3) begin
                add[COLLN] = CW'(1);
            end else if (TX_ATTEMPTS == 4'h2) begin
                add[COLL1] = CW'(1);
            end else if (TX_DEFERRED) begin
                add[DEFER1] = CW'(1);
            end
        end
        // only kinds 0 and 1 are tracked
        if (tx_fail && TX_FAIL_KIND == TXK_RETRY) begin
            add[XF_RETRY] = CW'(1);
        end
        if (tx_fail && TX_FAIL_KIND == TXK_NOCAR) begin
            add[XF_NOCAR] = CW'(1);
        end
        if (rx_fail && RX_ERR_KIND == RXK_CRC) begin
            add[RF_CRC] = CW'(1);
        end
        if (rx_fail && RX_ERR_KIND == RXK_ALIGN) begin
            add[RF_ALIGN] = CW'(1);
        end
        if (rx_fail && RX_ERR_KIND == RXK_OVER) begin
            add[RF_OVER] = CW'(1);
        end
        if (RX_UNMATCHED) begin
            add[UNMATCHED] = CW'(1);
        end
        if (RX_OVERRUN) begin
            add[OVERRUN] = CW'(1);
        end
        if (TX_CD_MISS && st_reg.fmt_new) begin
            add[CD_MISS] = CW'(1);
        end
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        st_next = st_reg;
        st_next.rdata = '0;
        cnt_off = ADDR - A_CNT_BASE;
        cnt_idx = cnt_off[AW-1:3];
        if (ctrl_wr) begin
            st_next.fmt_new = WDATA[CTRL_FMT_BIT];
        end
        st_next.tick_div = tick_pulse ? '0 : st_reg.tick_div + 8'h1;
        st_next.sec_div = sec_pulse ? '0 : st_reg.sec_div + 32'h1;
        // clear first so events of this cycle survive
        if (zero_req) begin
            st_next.cnt = '0;
            st_next.elapsed = '0;
            st_next.xf_cnt = '0;
            st_next.xf_map = '0;
            st_next.rf_cnt = '0;
            st_next.rf_map = '0;
            st_next.tick_div = '0;
            st_next.sec_div = '0;
        end else if (st_reg.fmt_new && tick_pulse) begin
            // newer format in 100 ns units
            st_next.elapsed = st_reg.elapsed + CW'(1);
        end else if (!st_reg.fmt_new && sec_pulse) begin
            // older format seconds, clamped at 16 bits
            st_next.elapsed = CW'(sat16(st_reg.elapsed[15:0]));
        end
        for (int i = 0; i < CNT_N; i++) begin
            st_next.cnt[i] = bump(st_next.cnt[i], add[i], !st_reg.fmt_new, old_width(i));
        end
        if (tx_fail && (TX_FAIL_KIND == TXK_RETRY || TX_FAIL_KIND == TXK_NOCAR)) begin
            st_next.xf_cnt = sat16(st_next.xf_cnt);
            st_next.xf_map[TX_FAIL_KIND] = 1'b1;
        end
        if (rx_fail) begin
            st_next.rf_cnt = sat16(st_next.rf_cnt);
            st_next.rf_map[RX_ERR_KIND - RXK_CRC] = 1'b1;
        end
        if (snap_req) begin
            st_next.snap = st_next.cnt;
            st_next.snap_elapsed = st_next.elapsed;
            st_next.snap_xf = {st_next.xf_map, st_next.xf_cnt};
            st_next.snap_rf = {st_next.rf_map, st_next.rf_cnt};
        end
        if (RD) begin
            if (ADDR == A_CTRL) begin
                st_next.rdata = 32'(st_reg.fmt_new);
            end else if (ADDR == A_STATUS) begin
                st_next.rdata = {st_reg.elapsed[15:0], 15'h0, st_reg.fmt_new};
            end else if (ADDR == A_ELAPSED_LO) begin
                st_next.rdata = st_reg.snap_elapsed[31:0];
            end else if (ADDR == A_ELAPSED_HI) begin
                st_next.rdata = st_reg.snap_elapsed[63:32];
            end else if (ADDR == A_XMIT_FAIL_OLD) begin
                st_next.rdata = st_reg.snap_xf;
            end else if (ADDR == A_RECV_FAIL_OLD) begin
                st_next.rdata = st_reg.snap_rf;
            end else if (ADDR >= A_ZERO_FIRST && ADDR <= A_ZERO_LAST) begin
                st_next.rdata = '0;
            end else if (ADDR >= A_CNT_BASE && ADDR[1:0] == 2'h0 && cnt_idx < IDX_W'(CNT_N)) begin
                // low word then high word per counter
                st_next.rdata = ADDR[2] ? st_reg.snap[cnt_idx][63:32] : st_reg.snap[cnt_idx][31:0];
            end
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            st_reg <= '0;
            st_reg.fmt_new <= CTRL_FMT_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    assign RDATA = st_reg.rdata;

endmodule : els_counters

//--- tb/els_counters_asserts.sv
// Purpose: Port-level checks of the statistics counter register port
// Assumes: One clock domain, reset active low
// Notes: Counter values are judged by the bench; these guard read framing
`timescale 1ns/100ps
module els_counters_asserts
    import els_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic RST_B,
    input wire logic [els_pkg::AW-1:0] ADDR,
    input wire logic WR,
    input wire logic RD,
    input wire logic [31:0] RDATA
);
    // ********
    // Read port
    // ********
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_B);
    a_rdata_idle_zero: assert property (!$past(RD) |-> RDATA == 32'h0)
        else $error("read data not zero outside a read");
    a_unaligned_zero: assert property (RD && ADDR[1:0] != 2'h0 |=> RDATA == 32'h0)
        else $error("unaligned read not zero");
    a_unused_zero: assert property (RD && ADDR >= A_ZERO_FIRST |=> RDATA == 32'h0)
        else $error("unsupported counter not zero");
    a_ctrl_bits_only: assert property (RD && ADDR == A_CTRL |=> RDATA[31:1] == 31'h0)
        else $error("control read shows extra bits");
    a_status_bits_only: assert property (RD && ADDR == A_STATUS |=> RDATA[15:1] == 15'h0)
        else $error("status read shows extra bits");
    a_xmit_kinds_only: assert property (RD && ADDR == A_XMIT_FAIL_OLD |=> RDATA[31:18] == 14'h0)
        else $error("send bitmap shows unsupported kind");
    a_recv_kinds_only: assert property (RD && ADDR == A_RECV_FAIL_OLD |=> RDATA[31:19] == 13'h0)
        else $error("receive bitmap shows unknown kind");
    a_snapshot_steady: assert property (RD ##1 (RD && $stable(ADDR) && ADDR != A_STATUS)
        |=> RDATA == $past(RDATA))
        else $error("snapshot changed between reads");
endmodule : els_counters_asserts

bind els_counters els_counters_asserts els_counters_asserts_inst (.SYS_CLK(SYS_CLK), .RST_B(RST_B),
    .ADDR(ADDR), .WR(WR), .RD(RD), .RDATA(RDATA));

//--- tb/els_ctrl_model.sv
// Purpose: Behavioural Ethernet controller reporting frame outcomes
// Assumes: Same clock as the counter block
// Notes: Idle qualifiers show inverted values so stale data is never counted
`timescale 1ns/100ps
module els_ctrl_model (
    input wire logic clk,
    output logic rx_evt,
    output logic [15:0] rx_len,
    output logic rx_grp,
    output logic rx_mt,
    output logic [1:0] rx_kd,
    output logic rx_unm,
    output logic rx_ovr,
    output logic tx_evt,
    output logic [15:0] tx_len,
    output logic [3:0] tx_att,
    output logic tx_dfr,
    output logic [2:0] tx_fk,
    output logic tx_cd
);
    initial begin
        {rx_evt, rx_len, rx_grp, rx_mt, rx_kd, rx_unm, rx_ovr} = '0;
        {tx_evt, tx_len, tx_att, tx_dfr, tx_fk, tx_cd} = '0;
    end
    task automatic rx(input logic [15:0] l, input logic g, input logic m, input logic [1:0] k);
        @(posedge clk);
        {rx_evt, rx_len, rx_grp, rx_mt, rx_kd} <= {1'b1, l, g, m, k};
        @(posedge clk);
        {rx_evt, rx_len, rx_grp, rx_mt, rx_kd} <= {1'b0, ~l, ~g, ~m, ~k};
    endtask : rx
    task automatic tx(input logic [15:0] l, input logic [3:0] a, input logic d, input logic [2:0] k);
        @(posedge clk);
        {tx_evt, tx_len, tx_att, tx_dfr, tx_fk} <= {1'b1, l, a, d, k};
        @(posedge clk);
        {tx_evt, tx_len, tx_att, tx_dfr, tx_fk} <= {1'b0, ~l, ~a, ~d, ~k};
    endtask : tx
    // strobes held n cycles count n times below saturation; tx_cd counts only in newer format
    task automatic pulse(input int s, input int n);
        @(posedge clk);
        {rx_unm, rx_ovr, tx_cd} <= 3'b100 >> s;
        repeat (n) @(posedge clk);
        {rx_unm, rx_ovr, tx_cd} <= 3'b000;
    endtask : pulse
endmodule : els_ctrl_model

//--- tb/els_counters_tb.sv
// Purpose: Self-checking bench for the link statistics counters
// Assumes: Register reads answer one cycle after the strobe
// Notes: Seconds shortened to 8 cycles; 64-bit wrap is out of reach
`timescale 1ns/100ps
module els_counters_tb;
    import els_pkg::*;
    logic sys_clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [7:0] addr = 8'h0;
    logic [31:0] wdata = 32'h0, rdata, v;
    logic rx_evt, rx_grp, rx_mt, rx_unm, rx_ovr, tx_evt, tx_dfr, tx_cd;
    logic [15:0] rx_len, tx_len;
    logic [1:0] rx_kd;
    logic [3:0] tx_att;
    logic [2:0] tx_fk;
    logic [63:0] ex [CNT_N];
    int err_count = 0, compares = 0;
    always #12.5 sys_clk = ~sys_clk;
    els_counters #(.SEC_CYC(8)) els_counters_inst (.SYS_CLK(sys_clk), .RST_B(rst_b), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .RX_EVT(rx_evt), .RX_LEN(rx_len),
        .RX_GROUP(rx_grp), .RX_ADDR_MATCH(rx_mt), .RX_ERR_KIND(rx_kd), .RX_UNMATCHED(rx_unm),
        .RX_OVERRUN(rx_ovr), .TX_EVT(tx_evt), .TX_LEN(tx_len), .TX_ATTEMPTS(tx_att),
        .TX_DEFERRED(tx_dfr), .TX_FAIL_KIND(tx_fk), .TX_CD_MISS(tx_cd));
    els_ctrl_model els_ctrl_model_inst (.clk(sys_clk), .rx_evt(rx_evt), .rx_len(rx_len), .rx_grp(rx_grp),
        .rx_mt(rx_mt), .rx_kd(rx_kd), .rx_unm(rx_unm), .rx_ovr(rx_ovr), .tx_evt(tx_evt), .tx_len(tx_len),
        .tx_att(tx_att), .tx_dfr(tx_dfr), .tx_fk(tx_fk), .tx_cd(tx_cd));
    // ********
    // Tasks
    // ********
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        {wr, addr, wdata} <= {1'b1, a, d};
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        {rd, addr} <= {1'b1, a};
        @(posedge sys_clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg
    task automatic reg_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        rd_reg(a, d);
        chk($sformatf("reg%h", a), {32'h0, e}, {32'h0, d});
    endtask : reg_chk
    // Two reads back to back with no gap; both must show the same snapshot word
    task automatic rd2_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d0, d1;
        @(posedge sys_clk);
        {rd, addr} <= {1'b1, a};
        @(posedge sys_clk);
        #1 d0 = rdata;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1 d1 = rdata;
        chk("rd_first", {32'h0, e}, {32'h0, d0});
        chk("rd_second", {32'h0, e}, {32'h0, d1});
    endtask : rd2_chk
    task automatic cnt(input int i, input logic [63:0] e);
        logic [31:0] lo, hi;
        rd_reg(A_CNT_BASE + 8'(8 * i), lo);
        rd_reg(A_CNT_BASE + 8'(8 * i + 4), hi);
        chk($sformatf("cnt%0d", i), e, {hi, lo});
    endtask : cnt
    task automatic tally_and_finish;
        $display("Compares %0d errors %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : tally_and_finish
    // ********
    // Tests
    // ********
    initial begin
        repeat (90000) @(posedge sys_clk);
        err_count++;
        tally_and_finish;
    end
    initial begin
        repeat (16) @(posedge sys_clk);
        rst_b <= 1'b1;
        reg_chk(A_CTRL, 32'h1);
        els_ctrl_model_inst.rx(100, 1, 1, RXK_NONE);
        els_ctrl_model_inst.rx(60, 0, 1, RXK_NONE);
        els_ctrl_model_inst.rx(40, 0, 1, RXK_CRC);
        els_ctrl_model_inst.rx(50, 1, 1, RXK_ALIGN);
        els_ctrl_model_inst.rx(70, 0, 1, RXK_OVER);
        els_ctrl_model_inst.rx(90, 0, 0, RXK_CRC);
        els_ctrl_model_inst.rx(30, 0, 0, RXK_NONE);
        els_ctrl_model_inst.pulse(0, 3);
        els_ctrl_model_inst.pulse(1, 2);
        els_ctrl_model_inst.pulse(2, 1);
        els_ctrl_model_inst.tx(200, 1, 1, TXK_NONE);
        els_ctrl_model_inst.tx(300, 2, 0, TXK_NONE);
        els_ctrl_model_inst.tx(400, 3, 0, TXK_NONE);
        els_ctrl_model_inst.tx(500, 5, 1, TXK_NONE);
        els_ctrl_model_inst.tx(600, 1, 0, TXK_NONE);
        els_ctrl_model_inst.tx(700, 1, 1, TXK_RETRY);
        els_ctrl_model_inst.tx(800, 2, 0, TXK_NOCAR);
        wr_reg(A_CTRL, 32'h5);
        ex = '{160, 2000, 2, 5, 100, 1, 1, 1, 2, 1, 1, 1, 1, 1, 3, 2, 1};
        for (int i = 0; i < CNT_N; i++) cnt(i, ex[i]);
        reg_chk(A_XMIT_FAIL_OLD, 32'h0003_0002);
        reg_chk(A_RECV_FAIL_OLD, 32'h0007_0003);
        rd2_chk(A_CNT_BASE, 32'd160);
        for (int a = 'ha0; a < 'h100; a += 4) reg_chk(8'(a), 32'h0);
        reg_chk(8'h11, 32'h0);
        els_ctrl_model_inst.rx(10, 0, 1, RXK_NONE);
        cnt(RX_FRM, 2);
        wr_reg(A_CTRL, 32'h7);
        for (int i = 0; i < CNT_N; i++) cnt(i, 64'h0);
        reg_chk(A_XMIT_FAIL_OLD, 32'h0);
        reg_chk(A_RECV_FAIL_OLD, 32'h0);
        reg_chk(A_ELAPSED_LO, 32'h0);
        repeat (400) @(posedge sys_clk);
        // Zero landed 476 edges before this snapshot; one tick per 4 edges
        wr_reg(A_CTRL, 32'h5);
        rd_reg(A_ELAPSED_LO, v);
        chk("elapsed_ticks", 64'd119, {32'h0, v});
        wr_reg(A_CTRL, 32'h6);
        repeat (80) @(posedge sys_clk);
        // Snapshot 82 edges after zero, status read 86 edges after: 10 seconds
        wr_reg(A_CTRL, 32'h4);
        rd_reg(A_ELAPSED_LO, v);
        chk("elapsed_secs", 64'd10, {32'h0, v});
        reg_chk(A_STATUS, 32'h000a_0000);
        reg_chk(A_CTRL, 32'h0);
        els_ctrl_model_inst.pulse(2, 1);
        wr_reg(A_CTRL, 32'h4);
        cnt(CD_MISS, 64'h0);
        wr_reg(A_CTRL, 32'h3);
        els_ctrl_model_inst.pulse(0, 65540);
        wr_reg(A_CTRL, 32'h5);
        cnt(UNMATCHED, 64'd65540);
        wr_reg(A_CTRL, 32'h4);
        els_ctrl_model_inst.pulse(0, 2);
        wr_reg(A_CTRL, 32'h4);
        cnt(UNMATCHED, 64'hffff);
        tally_and_finish;
    end
endmodule : els_counters_tb
